// ### rtl/tdm_core.sv
// Purpose: Top-down slot metrics, counter restrictions, off-core selection
// Assumes: Register port and event inputs synchronous to sys_clk
// Notes: Fractions refresh continuously while both the metrics and fixed counter 3 enables are set
`timescale 1ns/100ps
`default_nettype none
module tdm_core
#(
	parameter int CW = 48,
	parameter int IW = 4
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_idx,
	input wire logic [63:0] reg_wdata,
	output logic [63:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_err,
	// Slot events per cycle
	input wire logic [IW-1:0] slot_total_inc,
	input wire logic [tdm_pkg::TDM_NUM_METRICS-1:0][IW-1:0] slot_metric_inc,
	// General-purpose event occurrences
	input wire logic [tdm_pkg::TDM_NUM_GP-1:0] gp_event_pulse,
	output logic [tdm_pkg::TDM_NUM_GP-1:0] gp_blocked,
	// Off-core requests
	input wire logic oc_req_valid,
	input wire tdm_pkg::tdm_oc_kind_t oc_req_kind,
	output logic oc_count_pulse,
	// Status
	output logic metrics_active
);
	import tdm_pkg::*;

	typedef enum logic {
		SEQ_IDLE,
		SEQ_WAIT
	} tdm_seq_t;

	typedef struct packed {
		logic [63:0] ctrl;
		logic [CW-1:0] fctr3;
		logic [63:0] fractions;
		logic [63:0] oc_sel;
		logic [TDM_NUM_GP-1:0][15:0] evtsel;
		logic [TDM_NUM_GP-1:0][CW-1:0] gpctr;
		logic [TDM_NUM_METRICS-1:0][CW-1:0] acc;
		logic [TDM_NUM_METRICS-1:0][7:0] frac;
		tdm_seq_t seq;
		logic [2:0] idx;
		logic div_start;
		logic [CW-1:0] div_num;
		logic [CW-1:0] div_den;
		logic [63:0] rdata;
		logic rvalid;
		logic err;
		logic [TDM_NUM_GP-1:0] blocked;
		logic oc_pulse;
		logic active;
	} tdm_core_st_t;

	tdm_core_st_t st_reg;
	tdm_core_st_t st_next;
	logic [TDM_NUM_GP-1:0] allowed;
	logic div_done;
	logic [7:0] div_quot;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Clamp a child fraction under its parent
	function automatic logic [7:0] tdm_clamp(input logic [7:0] child,
		input logic [7:0] parent);
		return (child > parent) ? parent : child;
	endfunction : tdm_clamp

	// Request kind against the selector's request-type bits
	function automatic logic tdm_oc_hit(input tdm_oc_kind_t kind,
		input logic [63:0] sel);
		logic hit;
		case (kind)
			TDM_OC_WRITEBACK_DIRTY, TDM_OC_WRITEBACK_CLEAN:
				hit = sel[TDM_OC_WRITEBACK_LO]
					&& sel[TDM_OC_WRITEBACK_HI];
			TDM_OC_HW_L1D_PF:
				hit = sel[TDM_OC_HW_L1D_PF_BIT];
			TDM_OC_SW_PF_NTA, TDM_OC_SW_PF_T0, TDM_OC_SW_PF_T1,
			TDM_OC_SW_PF_T2:
				hit = sel[TDM_OC_SW_READ_PF_BIT];
			default:
				hit = 1'b0;
		endcase
		return hit;
	endfunction : tdm_oc_hit

	////////////////////////////////////////////////////////////////////////
	// Submodules

	tdm_event_gate u_gate
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.enc(st_reg.evtsel),
		.allowed(allowed)
	);

	tdm_frac_div #(.CW(CW)) u_div
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(st_reg.div_start),
		.num(st_reg.div_num),
		.den(st_reg.div_den),
		.done(div_done),
		.quot(div_quot)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic run;
		logic fx3_en;
		logic [4:0] rel;
		run = 1'b0;
		fx3_en = 1'b0;
		rel = 5'h00;
		st_next = st_reg;
		st_next.div_start = 1'b0;
		st_next.rvalid = 1'b0;
		st_next.err = 1'b0;

		fx3_en = st_reg.ctrl[TDM_CTRL_FIXED3_EN];
		run = fx3_en && st_reg.ctrl[TDM_CTRL_METRICS_EN];
		st_next.active = run;

		// Slot total and per-metric slot counts
		if (fx3_en)
			st_next.fctr3 = st_reg.fctr3 + CW'(slot_total_inc);
		if (run)
			for (int m = 0; m < TDM_NUM_METRICS; m++)
				st_next.acc[m] = st_reg.acc[m] + CW'(slot_metric_inc[m]);

		// Events count only where their encoding may run
		for (int i = 0; i < TDM_NUM_GP; i++)
		begin
			st_next.blocked[i] = !allowed[i];
			if (st_reg.ctrl[i] && gp_event_pulse[i] && allowed[i])
				st_next.gpctr[i] = st_reg.gpctr[i] + CW'(1);
		end

		st_next.oc_pulse = oc_req_valid && tdm_oc_hit(oc_req_kind,
			st_reg.oc_sel);

		// Fraction sequencer: one metric per division, publish after all
		case (st_reg.seq)
			SEQ_IDLE:
				if (run)
				begin
					st_next.div_num = st_reg.acc[st_reg.idx];
					st_next.div_den = st_reg.fctr3;
					st_next.div_start = 1'b1;
					st_next.seq = SEQ_WAIT;
				end
			SEQ_WAIT:
				if (div_done)
				begin
					st_next.frac[st_reg.idx] = div_quot;
					st_next.idx = st_reg.idx + 3'h1;
					st_next.seq = SEQ_IDLE;
					if (st_reg.idx == 3'(TDM_NUM_METRICS - 1))
					begin
						// Low half first-level, legacy order
						for (int k = 0; k < TDM_NUM_L1; k++)
						begin
							st_next.fractions[k*8 +: 8] =
								st_reg.frac[k];
							// Rounding could push a child past its parent
							st_next.fractions[(k+4)*8 +: 8] =
								tdm_clamp((k == 3) ? div_quot
								: st_reg.frac[k+4],
								st_reg.frac[k]);
						end
					end
				end
			default:
				st_next.seq = SEQ_IDLE;
		endcase

		// Register writes; software wins over the publish above
		if (reg_wr)
		begin
			if (reg_idx == TDM_IDX_FRACTIONS)
			begin
				// Restarting from a written value drops old slot history
				st_next.fractions = reg_wdata;
				st_next.acc = '0;
				st_next.idx = 3'h0;
			end
			else if (reg_idx == TDM_IDX_GLOBAL_CTRL)
				st_next.ctrl = reg_wdata & TDM_CTRL_WMASK;
			else if (reg_idx == TDM_IDX_FIXED_CTR3)
				st_next.fctr3 = reg_wdata[CW-1:0];
			else if (reg_idx == TDM_IDX_OC_SELECT)
				st_next.oc_sel = reg_wdata;
			else if (reg_idx[4:3] == TDM_IDX_EVTSEL_BASE[4:3])
				st_next.evtsel[reg_idx[2:0]] = reg_wdata[15:0];
			else if (reg_idx[4:3] == TDM_IDX_GPCTR_BASE[4:3])
				st_next.gpctr[reg_idx[2:0]] = reg_wdata[CW-1:0];
			else
				st_next.err = 1'b1;
		end

		// Register reads, one cycle later
		if (reg_rd)
		begin
			rel = reg_idx;
			st_next.rvalid = 1'b1;
			st_next.rdata = 64'h0;
			if (rel == TDM_IDX_FRACTIONS)
				st_next.rdata = st_reg.fractions;
			else if (rel == TDM_IDX_GLOBAL_CTRL)
				st_next.rdata = st_reg.ctrl;
			else if (rel == TDM_IDX_FIXED_CTR3)
				st_next.rdata = 64'(st_reg.fctr3);
			else if (rel == TDM_IDX_OC_SELECT)
				st_next.rdata = st_reg.oc_sel;
			else if (rel[4:3] == TDM_IDX_EVTSEL_BASE[4:3])
				st_next.rdata = 64'(st_reg.evtsel[rel[2:0]]);
			else if (rel[4:3] == TDM_IDX_GPCTR_BASE[4:3])
				st_next.rdata = 64'(st_reg.gpctr[rel[2:0]]);
			else
				st_next.err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.ctrl <= TDM_RST_64;
			st_reg.fractions <= TDM_RST_64;
			st_reg.oc_sel <= TDM_RST_64;
			st_reg.evtsel <= {TDM_NUM_GP{TDM_RST_EVTSEL}};
			st_reg.seq <= SEQ_IDLE;
		end
		else if (ce)
			st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign reg_err = st_reg.err;
	assign gp_blocked = st_reg.blocked;
	assign oc_count_pulse = st_reg.oc_pulse;
	assign metrics_active = st_reg.active;

endmodule : tdm_core
`default_nettype wire

// ### rtl/tdm_event_gate.sv
// Purpose: Registered counter eligibility for each programmed event
// Assumes: Encodings come straight from the event select registers
// Notes: One cycle behind a change of any event select register
`timescale 1ns/100ps
`default_nettype none
module tdm_event_gate
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Encodings per counter
	input wire logic [tdm_pkg::TDM_NUM_GP-1:0][15:0] enc,
	// Eligibility per counter
	output logic [tdm_pkg::TDM_NUM_GP-1:0] allowed
);
	import tdm_pkg::*;

	typedef struct packed {
		logic [TDM_NUM_GP-1:0] ok;
	} tdm_gate_st_t;

	tdm_gate_st_t st_reg;
	tdm_gate_st_t st_next;

	always_comb
	begin
		st_next = st_reg;
		for (int i = 0; i < TDM_NUM_GP; i++)
			st_next.ok[i] = tdm_allowed(enc[i], 3'(i));
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign allowed = st_reg.ok;

endmodule : tdm_event_gate
`default_nettype wire

// ### rtl/tdm_frac_div.sv
// Purpose: Sequential divider giving num*255/den as an 8-bit fraction
// Assumes: start only while idle; num and den held by the caller
// Notes: Eight steps; result saturates at full scale when num >= den, and is zero when den is zero
`timescale 1ns/100ps
`default_nettype none
module tdm_frac_div
#(
	parameter int CW = 48
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Request
	input wire logic start,
	input wire logic [CW-1:0] num,
	input wire logic [CW-1:0] den,
	// Result
	output logic done,
	output logic [7:0] quot
);
	import tdm_pkg::*;

	localparam int RW = CW + 8;

	typedef struct packed {
		logic busy;
		logic [2:0] step;
		logic [RW-1:0] rem;
		logic [RW-1:0] dsr;
		logic [7:0] q;
		logic done;
	} tdm_div_st_t;

	tdm_div_st_t st_reg;
	tdm_div_st_t st_next;

	always_comb
	begin
		logic [RW-1:0] trial;
		trial = '0;
		st_next = st_reg;
		st_next.done = 1'b0;
		if (!st_reg.busy && start)
		begin
			// Full scale 255 as (num << 8) - num keeps it shift-only
			st_next.rem = {num, 8'h00} - RW'(num);
			st_next.dsr = {1'b0, den, 7'h00};
			st_next.q = 8'h00;
			st_next.step = 3'h0;
			st_next.busy = (den != '0) && (num < den);
			st_next.done = !st_next.busy;
			if (den == '0)
				st_next.q = 8'h00;
			else if (num >= den)
				st_next.q = TDM_FRAC_FULL;
		end
		else if (st_reg.busy)
		begin
			trial = st_reg.rem - st_reg.dsr;
			if (st_reg.rem >= st_reg.dsr)
			begin
				st_next.rem = trial;
				st_next.q = {st_reg.q[6:0], 1'b1};
			end
			else
				st_next.q = {st_reg.q[6:0], 1'b0};
			st_next.dsr = st_reg.dsr >> 1;
			st_next.step = st_reg.step + 3'h1;
			if (st_reg.step == 3'(TDM_DIV_STEPS - 1))
			begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign done = st_reg.done;
	assign quot = st_reg.q;

endmodule : tdm_frac_div
`default_nettype wire

// ### rtl/tdm_pkg.sv
// Purpose: Shared constants and helpers for the top-down metrics block
// Assumes: Register indices are local to the block's register port
// Notes: Field positions and masks are used only by the core; the gate and divider use the event and fraction constants
package tdm_pkg;

	// Register port indices
	localparam logic [4:0] TDM_IDX_FRACTIONS = 5'h00;
	localparam logic [4:0] TDM_IDX_GLOBAL_CTRL = 5'h01;
	localparam logic [4:0] TDM_IDX_FIXED_CTR3 = 5'h02;
	localparam logic [4:0] TDM_IDX_OC_SELECT = 5'h03;
	localparam logic [4:0] TDM_IDX_EVTSEL_BASE = 5'h08;
	localparam logic [4:0] TDM_IDX_GPCTR_BASE = 5'h10;

	// Reset values
	localparam logic [63:0] TDM_RST_64 = 64'h0000_0000_0000_0000;
	localparam logic [15:0] TDM_RST_EVTSEL = 16'h0000;

	// Global control fields
	localparam int TDM_CTRL_FIXED3_EN = 35;
	localparam int TDM_CTRL_METRICS_EN = 48;
	localparam logic [63:0] TDM_CTRL_WMASK = 64'h0001_0008_0000_00FF;

	// Fraction fields
	localparam int TDM_FRAC_W = 8;
	localparam logic [7:0] TDM_FRAC_FULL = 8'hFF;
	localparam int TDM_NUM_METRICS = 8;
	localparam int TDM_NUM_L1 = 4;
	localparam int TDM_NUM_GP = 8;
	localparam int TDM_DIV_STEPS = 8;

	// Off-core selector request-type bits
	localparam int TDM_OC_WRITEBACK_LO = 3;
	localparam int TDM_OC_WRITEBACK_HI = 12;
	localparam int TDM_OC_HW_L1D_PF_BIT = 10;
	localparam int TDM_OC_SW_READ_PF_BIT = 14;

	// Event encoding thresholds and exceptions
	localparam logic [7:0] TDM_EV_SPLIT = 8'h90;
	localparam logic [7:0] TDM_EV_UNHALTED = 8'h3C;
	localparam logic [7:0] TDM_EV_LLC = 8'h2E;
	localparam logic [7:0] TDM_EV_MATRIX = 8'hCE;
	localparam logic [3:0] TDM_EV_MEMRET_HI = 4'hD;
	localparam logic [15:0] TDM_EV_CYC_A = 16'h01A3;
	localparam logic [15:0] TDM_EV_CYC_B = 16'h02A3;
	localparam logic [15:0] TDM_EV_CYC_C = 16'h08A3;
	localparam logic [15:0] TDM_EV_STORE_SMPL = 16'h02CD;
	localparam logic [15:0] TDM_EV_BADSPEC = 16'h04A4;
	localparam logic [15:0] TDM_EV_BRMISP = 16'h08A4;
	localparam logic [2:0] TDM_LOW_CTR_LAST = 3'h3;

	// Off-core request kinds seen by the block
	typedef enum logic [2:0] {
		TDM_OC_WRITEBACK_DIRTY,
		TDM_OC_WRITEBACK_CLEAN,
		TDM_OC_HW_L1D_PF,
		TDM_OC_SW_PF_NTA,
		TDM_OC_SW_PF_T0,
		TDM_OC_SW_PF_T1,
		TDM_OC_SW_PF_T2,
		TDM_OC_OTHER
	} tdm_oc_kind_t;

	// Counter eligibility of an event encoding {unit mask, event code}
	function automatic logic tdm_allowed(input logic [15:0] enc,
		input logic [2:0] ctr);
		logic [7:0] code;
		logic ok;
		code = enc[7:0];
		if (code == TDM_EV_UNHALTED || code == TDM_EV_LLC)
			ok = 1'b1;
		else if (code == TDM_EV_MATRIX || enc == TDM_EV_STORE_SMPL
			|| enc == TDM_EV_BADSPEC || enc == TDM_EV_BRMISP)
			ok = (ctr == 3'h0);
		else if (code[7:4] == TDM_EV_MEMRET_HI || enc == TDM_EV_CYC_A
			|| enc == TDM_EV_CYC_B || enc == TDM_EV_CYC_C)
			ok = (ctr <= TDM_LOW_CTR_LAST);
		else if (code < TDM_EV_SPLIT)
			ok = (ctr <= TDM_LOW_CTR_LAST);
		else
			ok = 1'b1;
		return ok;
	endfunction : tdm_allowed

endpackage : tdm_pkg

// ### verif/tdm_core_checker.sv
// Purpose: Port checks for the top-down metrics block
// Assumes: ce held high; register writes spaced at least six cycles apart
// Notes: Selector and enable shadows live in helper logic
`timescale 1ns/100ps
`default_nettype none
module tdm_core_checker
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_idx,
	input wire logic [63:0] reg_wdata,
	input wire logic [63:0] reg_rdata,
	input wire logic reg_rvalid,
	// Events and status
	input wire logic [tdm_pkg::TDM_NUM_GP-1:0] gp_blocked,
	input wire logic oc_req_valid,
	input wire tdm_pkg::tdm_oc_kind_t oc_req_kind,
	input wire logic oc_count_pulse,
	input wire logic metrics_active
);
	import tdm_pkg::*;
	logic [63:0] sel_reg;
	logic on_reg;
	logic rd0_reg;
	logic wr;
	logic [7:0] ev;
	assign wr = ce && reg_wr;
	assign ev = reg_wdata[7:0];
	////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_reg <= TDM_RST_64;
			on_reg <= 1'b0;
			rd0_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (reg_wr && reg_idx == TDM_IDX_OC_SELECT)
				sel_reg <= reg_wdata;
			if (reg_wr && reg_idx == TDM_IDX_GLOBAL_CTRL)
				on_reg <= reg_wdata[48] && reg_wdata[35];
			rd0_reg <= reg_rd && reg_idx == TDM_IDX_FRACTIONS;
		end
	end
	function automatic logic oc_hit(input tdm_oc_kind_t k,
		input logic [63:0] s);
		case (k)
			TDM_OC_WRITEBACK_DIRTY, TDM_OC_WRITEBACK_CLEAN:
				return s[3] && s[12];
			TDM_OC_HW_L1D_PF: return s[10];
			TDM_OC_OTHER: return 1'b0;
			default: return s[14];
		endcase
	endfunction : oc_hit
	////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	AST_METRICS_GATE: assert property (
		wr && reg_idx == TDM_IDX_GLOBAL_CTRL
		|-> ##3 metrics_active == on_reg)
		else $error("metrics enable wrong");
	AST_OC_COUNT: assert property (
		ce |=> oc_count_pulse == ($past(oc_req_valid)
		&& oc_hit($past(oc_req_kind), $past(sel_reg))))
		else $error("offcore count wrong");
	AST_CHILD_LE_PARENT: assert property (
		reg_rvalid && rd0_reg |-> reg_rdata[39:32] <= reg_rdata[7:0]
		&& reg_rdata[47:40] <= reg_rdata[15:8]
		&& reg_rdata[55:48] <= reg_rdata[23:16]
		&& reg_rdata[63:56] <= reg_rdata[31:24])
		else $error("child fraction above parent");
	AST_LOW_CODE_LOW_CTR: assert property (
		wr && reg_idx == 5'h0C && ev < TDM_EV_SPLIT && ev != 8'h3C
		&& ev != 8'h2E |-> ##3 gp_blocked[4])
		else $error("low code allowed on counter 4");
	AST_HIGH_CODE_ANY: assert property (
		wr && reg_idx == 5'h0E && ev[7:4] == 4'h9 |-> ##3 !gp_blocked[6])
		else $error("high code blocked on counter 6");
	AST_ARCH_ANY: assert property (
		wr && reg_idx == 5'h0F && (ev == 8'h3C || ev == 8'h2E)
		|-> ##3 !gp_blocked[7])
		else $error("architectural event blocked");
	AST_MEMRET_LOW: assert property (
		wr && reg_idx == 5'h0D && ev[7:4] == 4'hD |-> ##3 gp_blocked[5])
		else $error("retired memory event on counter 5");
	AST_CTR0_ONLY: assert property (
		wr && reg_idx == 5'h09 && (reg_wdata[15:0] == 16'h02CD
		|| reg_wdata[15:0] == 16'h04A4 || reg_wdata[15:0] == 16'h08A4
		|| ev == 8'hCE) |-> ##3 gp_blocked[1])
		else $error("counter 0 event on counter 1");
	COV_METRICS: cover property (wr ##3 metrics_active);
	COV_OC: cover property (oc_count_pulse);
	COV_BLOCK: cover property (gp_blocked[1] && !gp_blocked[0]);
endmodule : tdm_core_checker
bind tdm_core tdm_core_checker i_chk (.sys_clk, .rst_n, .ce, .reg_wr,
	.reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .reg_rvalid, .gp_blocked,
	.oc_req_valid, .oc_req_kind, .oc_count_pulse, .metrics_active);
`default_nettype wire

// ### verif/tdm_core_tb_top.sv
// Purpose: Self-checking bench for the top-down metrics block
// Assumes: ce held high; one idle cycle and four waits after each write, two waits after each read
// Notes: Reads are scored against a queue of expected words
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
	begin \
		num_checks++; \
		if ((a) !== (e)) \
		begin \
			fail_count++; \
			$display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
		end \
	end
module tdm_core_tb_top;
	import tdm_pkg::*;
	localparam logic [31:0] MINC = 32'h92331236;
	// {blocked, counter, encoding}
	localparam logic [19:0] TBL [17] = '{20'h002CD, 20'h902CD, 20'h904A4,
		20'h908A4, 20'h910CE, 20'hC01A3, 20'h302A3, 20'hD08A3, 20'h404A3,
		20'hD01D0, 20'h220DF, 20'h7003C, 20'h74F2E, 20'hC0010, 20'hC008F,
		20'h60090, 20'h30001};
	localparam logic [63:0] SELS [6] = '{64'h0, 64'h8, 64'h1008, 64'h400,
		64'h4000, 64'h5408};
	logic sys_clk, rst_n, ce, reg_wr, reg_rd, reg_rvalid, reg_err;
	logic oc_req_valid, oc_count_pulse, metrics_active;
	logic [4:0] reg_idx;
	logic [63:0] reg_wdata, reg_rdata, nexp, fr, sel;
	logic [3:0] slot_total_inc;
	logic [TDM_NUM_METRICS-1:0][3:0] slot_metric_inc;
	logic [TDM_NUM_GP-1:0] gp_event_pulse, gp_blocked;
	tdm_oc_kind_t oc_req_kind;
	logic [63:0] exp_q [$];
	logic err_q [$];
	logic nerr;
	logic [19:0] ent;
	int fail_count, num_checks, oc_cnt, i, k, f, n0, nexp_oc;
	tdm_core #(.CW(48), .IW(4)) i_dut (.sys_clk, .rst_n, .ce, .reg_wr,
		.reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_err,
		.slot_total_inc, .slot_metric_inc, .gp_event_pulse, .gp_blocked,
		.oc_req_valid, .oc_req_kind, .oc_count_pulse, .metrics_active);
	always #2 sys_clk = ~sys_clk;
	////////////////////////////////////////
	task automatic wr(input logic [4:0] idx, input logic [63:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_idx <= idx;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [4:0] idx, input logic [63:0] e);
		exp_q.push_back(e);
		// Only the mapped indices answer without an error
		err_q.push_back(!(idx <= TDM_IDX_OC_SELECT
			|| (idx >= TDM_IDX_EVTSEL_BASE
			&& idx < TDM_IDX_GPCTR_BASE + 5'h08)));
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_idx <= idx;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	always @(posedge sys_clk)
	begin
		if (reg_rvalid === 1'b1)
		begin
			nexp = exp_q.size() > 0 ? exp_q.pop_front() : ~64'h0;
			`CHK(reg_rdata, nexp)
			nerr = err_q.size() > 0 ? err_q.pop_front() : 1'b1;
			`CHK(reg_err, nerr)
		end
		if (oc_count_pulse === 1'b1)
			oc_cnt++;
	end
	initial
	begin
		{sys_clk, rst_n, reg_wr, reg_rd, oc_req_valid} = 5'h00;
		ce = 1'b1;
		reg_idx = 5'h00;
		reg_wdata = 64'h0;
		{slot_total_inc, slot_metric_inc, gp_event_pulse} = '0;
		oc_req_kind = TDM_OC_OTHER;
		{fail_count, num_checks, oc_cnt} = '0;
		void'($urandom(32'hB66E));
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(TDM_IDX_FRACTIONS, 64'h0);
		rd(5'h04, 64'h0);
		for (i = 0; i < 17; i++)
		begin
			ent = TBL[i];
			wr(5'h08 + {2'b00, ent[18:16]}, {48'h0, ent[15:0]});
			#1;
			`CHK(gp_blocked[ent[18:16]], ent[19])
		end
		for (i = 0; i < 8; i++)
		begin
			k = 4 + ($urandom % 4);
			wr(5'h08 + 5'(k), {48'h0, 8'($urandom), 4'h9, 4'($urandom)});
			#1;
			`CHK(gp_blocked[k], 1'b0)
		end
		// Counter 1 must stay still while counter 0 counts
		wr(5'h08, 64'h02CD);
		wr(5'h09, 64'h02CD);
		wr(TDM_IDX_GLOBAL_CTRL, 64'h3);
		repeat (5)
		begin
			@(posedge sys_clk);
			gp_event_pulse <= 8'h03;
		end
		@(posedge sys_clk);
		gp_event_pulse <= 8'h00;
		rd(TDM_IDX_GPCTR_BASE, 64'h5);
		rd(TDM_IDX_GPCTR_BASE + 5'h01, 64'h0);
		for (i = 0; i < 6; i++)
		begin
			sel = SELS[i];
			wr(TDM_IDX_OC_SELECT, sel);
			n0 = oc_cnt;
			for (k = 0; k < 8; k++)
			begin
				@(posedge sys_clk);
				oc_req_valid <= 1'b1;
				oc_req_kind <= tdm_oc_kind_t'(k[2:0]);
			end
			@(posedge sys_clk);
			oc_req_valid <= 1'b0;
			repeat (3) @(posedge sys_clk);
			nexp_oc = (sel[3] && sel[12] ? 2 : 0) + (sel[10] ? 1 : 0)
				+ (sel[14] ? 4 : 0);
			`CHK(oc_cnt - n0, nexp_oc)
		end
		// Clear both sides idle so the ratio is exact
		wr(TDM_IDX_GLOBAL_CTRL, 64'h0001_0008_0000_0000);
		wr(TDM_IDX_FIXED_CTR3, 64'h0);
		wr(TDM_IDX_FRACTIONS, 64'h0);
		@(posedge sys_clk);
		slot_total_inc <= 4'hC;
		slot_metric_inc <= MINC;
		repeat (40) @(posedge sys_clk);
		slot_total_inc <= 4'h0;
		slot_metric_inc <= '0;
		repeat (250) @(posedge sys_clk);
		for (k = 0; k < 8; k++)
		begin
			f = int'(MINC[k*4 +: 4]) * 255 / 12;
			if (k >= 4 && f > int'(fr[(k-4)*8 +: 8]))
				f = int'(fr[(k-4)*8 +: 8]);
			fr[k*8 +: 8] = 8'(f);
		end
		rd(TDM_IDX_FRACTIONS, fr);
		rd(TDM_IDX_FIXED_CTR3, 64'h1E0);
		wr(TDM_IDX_GLOBAL_CTRL, 64'h0000_0008_0000_0000);
		#1;
		`CHK(metrics_active, 1'b0)
		// Metrics bit alone must not start the metrics
		wr(TDM_IDX_GLOBAL_CTRL, 64'h0001_0000_0000_0000);
		#1;
		`CHK(metrics_active, 1'b0)
		for (i = 0; i < 20 && exp_q.size() > 0; i++)
			@(posedge sys_clk);
		if (exp_q.size() > 0)
			fail_count++;
		give_verdict();
	end
endmodule : tdm_core_tb_top
`default_nettype wire
